// ### core/spims_core.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "spims_map.svh"

module spims_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  // Register port
  input  wire spims_pkg::spims_bus_req_t   bus_req,
  output logic [7:0]                       rdata,
  // Serial pins
  input  wire spims_pkg::spims_pins_in_t   pins_in,
  output spims_pkg::spims_pins_out_t       pins_out,
  // Interrupt requests
  output logic                             rx_irq,
  output logic                             tx_irq
);
  import spims_pkg::*;

  if (ADDR_W != 8) begin : g_chk
    $error("spims_core supports an 8-bit register address only");
  end

  logic           rst_meta_q;
  logic           rst_n_q;
  spims_pins_in_t pin_meta_q;
  spims_pins_in_t pin_q;
  logic           sck_prev_q;
  logic           ss_prev_q;
  logic [7:0]     ctrl_q;
  logic [7:0]     ctrl_d;
  logic           err_ie_q;
  logic           mf_en_q;
  logic [1:0]     rate_q;
  logic           rx_full_q;
  logic           ovr_q;
  logic           mf_q;
  logic           tx_empty_q;
  logic           rx_armed_q;
  logic           ovr_armed_q;
  logic           mf_armed_q;
  logic [7:0]     rx_data_q;
  logic [7:0]     tx_buf_q;
  logic [7:0]     sh_q;
  logic           sh_empty_q;
  logic           busy_q;
  logic           drop_q;
  logic [3:0]     edge_q;
  logic           bit_q;
  logic           sck_q;
  logic [6:0]     div_q;
  logic [7:0]     rdata_q;
  logic           rx_irq_q;
  logic           tx_irq_q;

  // Reset release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
      pin_q      <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
      sck_prev_q <= 1'b0;
      ss_prev_q  <= 1'b1;
    end else begin
      pin_meta_q <= pins_in;
      pin_q      <= pin_meta_q;
      sck_prev_q <= pin_q.sck;
      ss_prev_q  <= pin_q.ss_n;
    end
  end

  // Register decode
  wire sel_ctl = bus_req.addr == `SPIMS_OFF_CTL;
  wire sel_scr = bus_req.addr == `SPIMS_OFF_SCR;
  wire sel_dat = bus_req.addr == `SPIMS_OFF_DAT;
  wire wr_ctl  = bus_req.wr & sel_ctl;
  wire wr_scr  = bus_req.wr & sel_scr;
  wire wr_dat  = bus_req.wr & sel_dat;
  wire rd_scr  = bus_req.rd & sel_scr;
  wire rd_dat  = bus_req.rd & sel_dat;

  wire en     = ctrl_q[`SPIMS_CTL_EN];
  wire clock_phase_bit   = ctrl_q[`SPIMS_CTL_CLOCK_PHASE_BIT];
  wire clock_polarity_bit   = ctrl_q[`SPIMS_CTL_CLOCK_POLARITY_BIT];
  wire m_mode = en & ctrl_q[`SPIMS_CTL_MASTER];
  wire t_mode = en & ~ctrl_q[`SPIMS_CTL_MASTER];

  wire [6:0] rmask = spims_rate_mask(rate_q);
  wire       tick  = (div_q & rmask) == rmask;

  wire sck_edge = pin_q.sck ^ sck_prev_q;
  wire tgt_sel  = ~pin_q.ss_n;
  wire ss_fall  = ss_prev_q & ~pin_q.ss_n;

  wire m_start = m_mode & ~busy_q & ~sh_empty_q & tick;
  wire t_start = t_mode & ~busy_q & tgt_sel & (clock_phase_bit ? sck_edge : ss_fall);
  wire m_edge  = m_mode & busy_q & tick;
  wire t_edge  = (t_mode & busy_q & tgt_sel & sck_edge) | (t_start & clock_phase_bit);
  wire edge_ev = m_edge | t_edge;
  wire t_abort = busy_q & ((t_mode & pin_q.ss_n) | ~en);

  wire       lead     = ~edge_q[0];
  wire       sample   = lead ^ clock_phase_bit;
  wire       samp_ev  = edge_ev & sample;
  wire       shift_ev = edge_ev & ~sample & (edge_q != 4'h0);
  wire       done     = edge_ev & (edge_q == `SPIMS_LAST_EDGE);
  wire       din      = m_mode ? pin_q.miso : pin_q.mosi;
  wire [7:0] rx_byte  = sample ? {sh_q[6:0], din} : {sh_q[6:0], bit_q};

  wire load_ev = ~busy_q & ~tx_empty_q & sh_empty_q & ~wr_dat;
  wire mf_set  = m_mode & mf_en_q & tgt_sel;
  wire bit1_ev = samp_ev & (edge_q[3:1] == `SPIMS_BIT1_SLOT);
  wire ovr_set = bit1_ev & rx_full_q;
  // Overrun frame never reaches the receive register
  wire rxf_set = done & ~rx_full_q & ~drop_q;

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctl) begin
      ctrl_d = bus_req.wdata & `SPIMS_CTL_WMASK;
    end
    if (wr_dat) begin
      ctrl_d[`SPIMS_CTL_TXIE] = 1'b0;
    end
    if (mf_set) begin
      ctrl_d[`SPIMS_CTL_EN] = 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q   <= `SPIMS_CTL_RST;
      err_ie_q <= 1'b0;
      mf_en_q  <= 1'b0;
      rate_q   <= 2'h0;
      tx_buf_q <= `SPIMS_BYTE_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_scr) begin
        err_ie_q <= bus_req.wdata[`SPIMS_SCR_ERRIE];
        mf_en_q  <= bus_req.wdata[`SPIMS_SCR_MFEN];
        rate_q   <= bus_req.wdata[`SPIMS_SCR_RATE_HI:`SPIMS_SCR_RATE_LO];
      end
      if (wr_dat) begin
        tx_buf_q <= bus_req.wdata;
      end
    end
  end

  // Status flags
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_full_q   <= 1'b0;
      ovr_q       <= 1'b0;
      mf_q        <= 1'b0;
      tx_empty_q  <= 1'b1;
      rx_armed_q  <= 1'b0;
      ovr_armed_q <= 1'b0;
      mf_armed_q  <= 1'b0;
      rx_data_q   <= `SPIMS_BYTE_RST;
    end else begin
      if (rxf_set) begin
        rx_data_q <= rx_byte;
      end
      if (rxf_set) begin
        rx_full_q <= 1'b1;
      end else if (rd_dat & rx_armed_q) begin
        rx_full_q <= 1'b0;
      end
      if (rd_scr & rx_full_q) begin
        rx_armed_q <= 1'b1;
      end else if (rd_dat) begin
        rx_armed_q <= 1'b0;
      end
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (rd_dat & ovr_armed_q) begin
        ovr_q <= 1'b0;
      end
      if (rd_scr & ovr_q) begin
        ovr_armed_q <= 1'b1;
      end else if (rd_dat) begin
        ovr_armed_q <= 1'b0;
      end
      if (mf_set) begin
        mf_q <= 1'b1;
      end else if (wr_ctl & mf_armed_q) begin
        mf_q <= 1'b0;
      end
      if (rd_scr & mf_q) begin
        mf_armed_q <= 1'b1;
      end else if (wr_ctl) begin
        mf_armed_q <= 1'b0;
      end
      if (load_ev) begin
        tx_empty_q <= 1'b1;
      end else if (wr_dat) begin
        tx_empty_q <= 1'b0;
      end
    end
  end

  // Shifter and sequencing
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sh_q       <= `SPIMS_BYTE_RST;
      sh_empty_q <= 1'b1;
      busy_q     <= 1'b0;
      drop_q     <= 1'b0;
      edge_q     <= 4'h0;
      bit_q      <= 1'b0;
    end else begin
      if (done | ~busy_q) begin
        drop_q <= 1'b0;
      end else if (ovr_set) begin
        drop_q <= 1'b1;
      end
      if (load_ev) begin
        sh_q       <= tx_buf_q;
        sh_empty_q <= 1'b0;
      end else if (done) begin
        sh_q       <= rx_byte;
        sh_empty_q <= 1'b1;
      end else if (shift_ev) begin
        sh_q <= {sh_q[6:0], bit_q};
      end
      if (samp_ev) begin
        bit_q <= din;
      end
      if (done | t_abort) begin
        busy_q <= 1'b0;
      end else if (m_start | t_start) begin
        busy_q <= 1'b1;
      end
      if (~busy_q & ~t_start) begin
        edge_q <= 4'h0;
      end else if (edge_ev) begin
        edge_q <= edge_q + 4'h1;
      end
    end
  end

  // Controller clock
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= 7'h00;
      sck_q <= 1'b0;
    end else begin
      div_q <= m_mode ? div_q + 7'h01 : 7'h00;
      if (~busy_q | ~m_mode) begin
        sck_q <= clock_polarity_bit;
      end else if (m_edge) begin
        sck_q <= ~sck_q;
      end
    end
  end

  // Read data and interrupts
  wire [7:0] scr_val = {rx_full_q, err_ie_q, ovr_q, mf_q, tx_empty_q, mf_en_q, rate_q};
  wire [7:0] rd_mux  = sel_ctl ? ctrl_q :
                       sel_scr ? scr_val :
                       sel_dat ? rx_data_q : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q  <= 8'h00;
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      rdata_q  <= bus_req.rd ? rd_mux : 8'h00;
      rx_irq_q <= (rx_full_q & ctrl_q[`SPIMS_CTL_RXIE]) | (err_ie_q & (ovr_q | mf_q));
      tx_irq_q <= tx_empty_q & ctrl_q[`SPIMS_CTL_TXIE];
    end
  end

  assign rdata  = rdata_q;
  assign rx_irq = rx_irq_q;
  assign tx_irq = tx_irq_q;

  assign pins_out.sck_o   = sck_q;
  assign pins_out.sck_oe  = m_mode;
  assign pins_out.mosi_o  = sh_q[7];
  assign pins_out.mosi_oe = m_mode;
  assign pins_out.miso_o  = sh_q[7];
  assign pins_out.miso_oe = t_mode & tgt_sel;

endmodule

// ### core/spims_map.svh
`ifndef SPIMS_MAP_SVH
`define SPIMS_MAP_SVH

// Register offsets
`define SPIMS_OFF_CTL     8'h10
`define SPIMS_OFF_SCR     8'h11
`define SPIMS_OFF_DAT     8'h12

// Control register fields
`define SPIMS_CTL_RXIE    7
`define SPIMS_CTL_MASTER  5
`define SPIMS_CTL_CLOCK_POLARITY_BIT    4
`define SPIMS_CTL_CLOCK_PHASE_BIT    3
`define SPIMS_CTL_EN      1
`define SPIMS_CTL_TXIE    0
`define SPIMS_CTL_WMASK   8'hBB
`define SPIMS_CTL_RST     8'h00

// Status/control register fields
`define SPIMS_SCR_RXF     7
`define SPIMS_SCR_ERRIE   6
`define SPIMS_SCR_OVR     5
`define SPIMS_SCR_MF      4
`define SPIMS_SCR_TXE     3
`define SPIMS_SCR_MFEN    2
`define SPIMS_SCR_RATE_HI 1
`define SPIMS_SCR_RATE_LO 0

// Half-period masks for divide by 2, 8, 32, 128
`define SPIMS_MASK_DIV2   7'h00
`define SPIMS_MASK_DIV8   7'h03
`define SPIMS_MASK_DIV32  7'h0F
`define SPIMS_MASK_DIV128 7'h3F

// Transfer framing
`define SPIMS_LAST_EDGE   4'hF
// Edge pair that carries the bit-1 capture
`define SPIMS_BIT1_SLOT   3'h6
`define SPIMS_BYTE_RST    8'h00

`endif

// ### core/spims_pkg.sv
`include "spims_map.svh"

package spims_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spims_bus_req_t;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
  } spims_pins_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spims_pins_out_t;

  function automatic logic [6:0] spims_rate_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    spims_rate_mask = `SPIMS_MASK_DIV2;
      2'h1:    spims_rate_mask = `SPIMS_MASK_DIV8;
      2'h2:    spims_rate_mask = `SPIMS_MASK_DIV32;
      default: spims_rate_mask = `SPIMS_MASK_DIV128;
    endcase
  endfunction

endpackage

// ### verif/spims_asserts.sv
`timescale 1ns/100ps
`include "spims_map.svh"
module spims_asserts (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       resetn,
  // Register port
  input wire spims_pkg::spims_bus_req_t  bus_req,
  input wire logic [7:0]                 rdata,
  // Serial pins and requests
  input wire spims_pkg::spims_pins_in_t  pins_in,
  input wire spims_pkg::spims_pins_out_t pins_out,
  input wire logic                       rx_irq,
  input wire logic                       tx_irq
);
  import spims_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire dat_wr = bus_req.wr && bus_req.addr == `SPIMS_OFF_DAT;
  wire bad_rd = bus_req.rd && (bus_req.addr < `SPIMS_OFF_CTL || bus_req.addr > `SPIMS_OFF_DAT);

  ctl_drives_a: assert property (pins_out.sck_oe |-> pins_out.mosi_oe)
    else $error("clock driven without data line");
  role_excl_a: assert property (pins_out.miso_oe |-> !pins_out.sck_oe)
    else $error("both roles drive at once");
  sck_owner_a: assert property ($changed(pins_out.sck_o) |-> pins_out.sck_oe)
    else $error("clock moves outside controller role");
  mosi_hold_a: assert property (pins_out.sck_o |-> $stable(pins_out.mosi_o))
    else $error("data changes while clock high");
  unsel_quiet_a: assert property (pins_in.ss_n [*3] |=> !pins_out.miso_oe)
    else $error("unselected target drives data");
  txie_clear_a: assert property (dat_wr |-> ##2 !tx_irq)
    else $error("transmit request after data write");
  rd_window_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  unmapped_a: assert property (bad_rd |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind spims_core spims_asserts i_chk (.ref_clk, .resetn, .bus_req, .rdata, .pins_in, .pins_out,
  .rx_irq, .tx_irq);

// ### verif/spims_peer.sv
`timescale 1ns/100ps
module spims_peer (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso = 1'b0,
  output logic [7:0]      rx_byte = 8'h00,
  output int              n_rx = 0
);
  logic [7:0] sh = 8'h00;
  logic [2:0] cnt = 3'h0;
  // Released line shows the inverse of its last value
  always @(posedge ss_n) miso = ~miso;
  always @(negedge ss_n) begin
    sh = tx_byte;
    cnt = 3'h0;
    miso = tx_byte[7];
  end
  always @(posedge sck) if (!ss_n) begin
    sh = {sh[6:0], mosi};
    cnt = cnt + 3'h1;
    if (cnt == 3'h0) begin
      rx_byte = sh;
      n_rx++;
      sh = tx_byte;
    end
  end
  always @(negedge sck) if (!ss_n) miso = sh[7];
endmodule

// ### verif/tb.sv
`timescale 1ns/100ps
`include "spims_map.svh"
`define CHECK_EQ(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  import spims_pkg::*;
  logic            ref_clk = 1'b0;
  logic            resetn = 1'b0;
  spims_bus_req_t  bus_req = '0;
  spims_pins_in_t  pins_in;
  spims_pins_out_t o;
  logic [7:0]      rdata, rd_v, p_rx;
  logic [7:0]      p_tx = 8'hA5;
  logic            t_sck = 1'b0, t_ss_n = 1'b1, t_mosi = 1'b0, p_ss_n = 1'b1;
  logic            p_miso, rx_irq, tx_irq;
  int              mismatches = 0, n_compared = 0, p_n;
  wire sck_w = o.sck_oe ? o.sck_o : t_sck;
  wire mosi_w = o.mosi_oe ? o.mosi_o : t_mosi;
  wire miso_w = o.miso_oe ? o.miso_o : p_miso;
  assign pins_in = {sck_w, t_ss_n, mosi_w, miso_w};
  always #10 ref_clk = ~ref_clk;

  spims_core i_dut (.ref_clk, .resetn, .bus_req, .rdata, .pins_in, .pins_out(o), .rx_irq,
    .tx_irq);
  spims_peer i_peer (.sck(sck_w), .ss_n(p_ss_n), .mosi(mosi_w), .tx_byte(p_tx), .miso(p_miso),
    .rx_byte(p_rx), .n_rx(p_n));

  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    stop_test();
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    reg_rd(a, rd_v);
    `CHECK_EQ(rd_v, e)
  endtask
  task automatic wait_sck();
    int i;
    for (i = 0; i < 300 && o.sck_o !== 1'b1; i++) @(posedge ref_clk) #1;
    if (i == 300) hang();
  endtask
  task automatic poll_scr(input int b);
    int i;
    rd_v = 8'h00;
    for (i = 0; i < 1000 && rd_v[b] !== 1'b1; i++) reg_rd(`SPIMS_OFF_SCR, rd_v);
    if (i == 1000) hang();
  endtask

  task automatic t_reset();
    expect_reg(`SPIMS_OFF_SCR, 8'h08);
    reg_wr(8'h0F, 8'hFF);
    expect_reg(`SPIMS_OFF_CTL, `SPIMS_CTL_RST);
    expect_reg(8'h13, 8'h00);
  endtask
  task automatic t_ctl();
    p_ss_n <= 1'b0;
    reg_wr(`SPIMS_OFF_SCR, 8'h02);
    reg_wr(`SPIMS_OFF_CTL, 8'h23);
    p_tx <= 8'h69;
    repeat (2) @(posedge ref_clk);
    #1 `CHECK_EQ(tx_irq, 1'b1)
    reg_wr(`SPIMS_OFF_DAT, 8'h3C);
    expect_reg(`SPIMS_OFF_SCR, 8'h0A);
    expect_reg(`SPIMS_OFF_CTL, 8'h22);
    `CHECK_EQ(tx_irq, 1'b0)
    wait_sck();
    reg_wr(`SPIMS_OFF_DAT, 8'h96);
    expect_reg(`SPIMS_OFF_SCR, 8'h02);
    poll_scr(5);
    expect_reg(`SPIMS_OFF_SCR, 8'hAA);
    expect_reg(`SPIMS_OFF_DAT, 8'hA5);
    expect_reg(`SPIMS_OFF_SCR, 8'h0A);
    repeat (64) @(posedge ref_clk);
    expect_reg(`SPIMS_OFF_SCR, 8'h0A);
    `CHECK_EQ(p_rx, 8'h96)
    `CHECK_EQ(p_n, 2)
  endtask
  task automatic t_rates();
    int n;
    for (int r = 0; r < 4; r++) begin
      reg_wr(`SPIMS_OFF_SCR, 8'(r));
      reg_wr(`SPIMS_OFF_DAT, 8'hFF);
      wait_sck();
      for (n = 0; n < 200 && o.sck_o === 1'b1; n++) @(posedge ref_clk) #1;
      `CHECK_EQ(n, 1 << (2 * r))
      poll_scr(7);
      reg_rd(`SPIMS_OFF_DAT, rd_v);
    end
  endtask
  task automatic t_target();
    logic [7:0] got;
    logic [7:0] d;
    d = 8'hC3;
    p_ss_n <= 1'b1;
    t_sck <= 1'b0;
    // role chosen while disabled, then enabled
    reg_wr(`SPIMS_OFF_CTL, 8'h00);
    reg_wr(`SPIMS_OFF_CTL, 8'h82);
    reg_wr(`SPIMS_OFF_DAT, 8'h5A);
    t_ss_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      t_mosi <= d[b];
      repeat (8) @(posedge ref_clk);
      got[b] = o.miso_o;
      t_sck <= 1'b1;
      repeat (8) @(posedge ref_clk);
      t_sck <= 1'b0;
    end
    `CHECK_EQ(o.miso_oe, 1'b1)
    repeat (8) @(posedge ref_clk);
    t_ss_n <= 1'b1;
    poll_scr(7);
    `CHECK_EQ(rx_irq, 1'b1)
    expect_reg(`SPIMS_OFF_DAT, 8'hC3);
    `CHECK_EQ(got, 8'h5A)
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_ctl();
    t_rates();
    t_target();
    stop_test();
  end
endmodule
